//--- rtl/cie_irq_core.sv
// Interrupt entry and return sequencing of an 8-bit core.
// Assumes a sequencer that pulses instruction events at each instruction end
// and a byte stack memory returning read data one cycle after a read request.
// Functional notes
// - Take a source only with its own enable and the global enable both set.
// - Lower vector address wins; reset first, then the lowest source.
// - Vector table select moves the table to the boot section start.
// - Boot reset fuse moves the reset vector to the boot section start.
// - Lock bits may suppress interrupts depending on program counter region.
// - Accepting an interrupt clears the global enable.
// - Global enable set in a handler lets interrupts nest.
// - Return from interrupt sets the global enable.
// - Vectoring to a flagged source clears its flag in hardware.
// - Writing one to a flag clears it; zeros leave flags alone.
// - Events while disabled still set the flag, held until served or cleared.
// - Flags set while globally disabled stay pending, served by priority later.
// - Level sources request only while their condition stands.
// - After return, one program instruction runs before any pending service.
// - Status register is neither saved on entry nor restored on return.
// - Clearing the global enable with cli acts at once, even on a coincident request.
// - The instruction after sei runs before service; a status register write setting the global enable gets no such delay.
// - Entry takes four cycles pushing the program counter, then the vector.
// - A running multi-cycle instruction completes before entry begins.
// - Waking from sleep adds four cycles to entry.
// - Return takes four cycles, pops two bytes, stack pointer plus two.
// - Entry push lowers the stack pointer by two.
// - Global enable is bit 7 of the status register.
`timescale 1ns/10ps
module cie_irq_core
  import cie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CIE_NSRC-1:0] src_event,
  input wire logic [CIE_NSRC-1:0] src_level,
  input wire logic [CIE_NSRC-1:0] src_enable,
  input wire logic flag_clr_wr,
  input wire logic [CIE_NSRC-1:0] flag_clr_data,
  input wire logic vector_table_select,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_irq_bit,
  input wire logic boot_lock_irq_bit,
  input wire logic pc_in_boot,
  input wire logic cpu_sleeping,
  input wire cie_instr_t instr,
  input wire cie_core_status_register_wr_t core_status_register_wr,
  input wire logic sp_wr,
  input wire logic [CIE_SP_W-1:0] sp_wdata,
  input wire logic [CIE_PC_W-1:0] pc_cur,
  input wire logic [7:0] stack_rdata,
  output logic [CIE_NSRC-1:0] irq_flags,
  output logic global_irq_enable,
  output logic seq_hold,
  output logic irq_taken,
  output logic pc_load,
  output logic [CIE_PC_W-1:0] pc_load_addr,
  output cie_stack_t stack,
  output logic [CIE_SP_W-1:0] stack_ptr
);

  cie_state_t st_ff;
  cie_state_t nxt_st;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic gie_ff;
  logic nxt_gie;
  logic [CIE_SP_W-1:0] sp_ff;
  logic [CIE_SP_W-1:0] nxt_sp;
  logic [CIE_PC_W-1:0] ret_pc_ff;
  logic [CIE_PC_W-1:0] vec_ff;
  logic [6:0] pop_hi_ff;
  logic pc_load_ff;
  logic nxt_pc_load;
  logic [CIE_PC_W-1:0] pc_addr_ff;
  logic [CIE_PC_W-1:0] nxt_pc_addr;
  cie_stack_t stack_ff;
  cie_stack_t nxt_stack;
  logic taken_ff;

  logic [CIE_NSRC-1:0] pending;
  logic [CIE_NSRC-1:0] win_onehot;
  logic [CIE_NSRC-1:0] hw_clr;
  logic win_valid;
  logic [CIE_PC_W-1:0] win_vec;
  logic gie_eff;
  logic lock_block;
  logic at_boundary;
  logic accept;
  logic ret_start;
  logic last_cnt;
  logic [CIE_PC_W-1:0] reset_vec;

  cie_flag_bank u_flags (
    .sys_clk(sys_clk),
    .rst(rst),
    .src_event(src_event),
    .src_level(src_level),
    .src_enable(src_enable),
    .sw_clr_wr(flag_clr_wr),
    .sw_clr_data(flag_clr_data),
    .hw_clr(hw_clr),
    .flags(irq_flags),
    .pending(pending)
  );

  cie_vec_sel u_sel (
    .pending(pending),
    .tbl_sel(vector_table_select),
    .valid(win_valid),
    .onehot(win_onehot),
    .vec_addr(win_vec)
  );

  // A cli in the same cycle masks a coincident request
  assign gie_eff = gie_ff & ~instr.cli;
  // Region-based suppression, each lock bit guarding its own section
  assign lock_block = (app_lock_irq_bit & ~pc_in_boot) | (boot_lock_irq_bit & pc_in_boot);
  // Only at the end of a whole instruction, or while asleep
  assign at_boundary = (instr.boundary | cpu_sleeping) & (st_ff == CIE_ST_RUN);
  // gie_ff also rises on a status register write, which is not masked here; after sei or return the next instruction always completes first
  assign accept = at_boundary & gie_eff & win_valid & ~lock_block & ~instr.sei & ~instr.return_from_irq_instr;
  assign hw_clr = accept ? win_onehot : '0;
  assign ret_start = (st_ff == CIE_ST_RUN) & instr.return_from_irq_instr & instr.boundary;
  assign reset_vec = boot_reset_fuse ? CIE_BOOT_START : CIE_APP_START;
  assign last_cnt = (cnt_ff == CIE_ENTRY_CYC - 3'h1);

  // Global enable; bit 7 of the status byte is the only bit held here
  always_comb
  begin
    nxt_gie = gie_ff;
    if (core_status_register_wr.wr)
      nxt_gie = core_status_register_wr.data[CIE_GIE_BIT];
    if (instr.sei)
      nxt_gie = 1'b1;
    if (instr.cli)
      nxt_gie = 1'b0;
    if (accept)
      nxt_gie = 1'b0;
    if (st_ff == CIE_ST_RETURN && cnt_ff == CIE_RET_CYC - 3'h1)
      nxt_gie = 1'b1;
  end

  // Sequencer; the other status bits are never touched here
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff + 3'h1;
    nxt_sp = sp_wr ? sp_wdata : sp_ff;
    nxt_pc_load = 1'b0;
    nxt_pc_addr = pc_addr_ff;
    nxt_stack = '0;
    unique case (st_ff)
      CIE_ST_BOOT:
      begin
        // Reset outranks everything: first act is the reset vector
        nxt_pc_load = 1'b1;
        nxt_pc_addr = reset_vec;
        nxt_st = CIE_ST_RUN;
        nxt_cnt = '0;
      end
      CIE_ST_RUN:
      begin
        nxt_cnt = '0;
        if (accept)
          nxt_st = cpu_sleeping ? CIE_ST_WAKE : CIE_ST_ENTRY;
        else if (ret_start)
          nxt_st = CIE_ST_RETURN;
      end
      CIE_ST_WAKE:
      begin
        if (cnt_ff == CIE_WAKE_CYC - 3'h1)
        begin
          nxt_st = CIE_ST_ENTRY;
          nxt_cnt = '0;
        end
      end
      CIE_ST_ENTRY:
      begin
        if (cnt_ff == 3'h0)
        begin
          nxt_stack = '{wr: 1'b1, rd: 1'b0, addr: sp_ff, wdata: ret_pc_ff[7:0]};
          nxt_sp = sp_ff - 16'h0001;
        end
        if (cnt_ff == 3'h1)
        begin
          nxt_stack = '{wr: 1'b1, rd: 1'b0, addr: sp_ff, wdata: {1'b0, ret_pc_ff[14:8]}};
          nxt_sp = sp_ff - 16'h0001;
        end
        if (last_cnt)
        begin
          nxt_pc_load = 1'b1;
          nxt_pc_addr = vec_ff;
          nxt_st = CIE_ST_RUN;
        end
      end
      CIE_ST_RETURN:
      begin
        if (cnt_ff == 3'h0 || cnt_ff == 3'h1)
        begin
          nxt_stack = '{wr: 1'b0, rd: 1'b1, addr: sp_ff + 16'h0001, wdata: 8'h00};
          nxt_sp = sp_ff + 16'h0001;
        end
        if (cnt_ff == CIE_RET_CYC - 3'h1)
        begin
          // High byte sits at the lower address, so it came back first
          nxt_pc_load = 1'b1;
          nxt_pc_addr = {pop_hi_ff, stack_rdata};
          nxt_st = CIE_ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_ff <= CIE_ST_BOOT;
      cnt_ff <= '0;
      gie_ff <= CIE_GIE_RST;
      sp_ff <= CIE_SP_RST;
      pc_load_ff <= 1'b0;
      pc_addr_ff <= '0;
      stack_ff <= '0;
      taken_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      gie_ff <= nxt_gie;
      sp_ff <= nxt_sp;
      pc_load_ff <= nxt_pc_load;
      pc_addr_ff <= nxt_pc_addr;
      stack_ff <= nxt_stack;
      taken_ff <= accept;
    end
  end

  // Data-only captures, no reset needed
  always_ff @(posedge sys_clk)
  begin
    if (accept)
    begin
      ret_pc_ff <= pc_cur;
      vec_ff <= win_vec;
    end
    if (st_ff == CIE_ST_RETURN && cnt_ff == 3'h2)
      pop_hi_ff <= stack_rdata[6:0];
  end

  assign global_irq_enable = gie_ff;
  assign seq_hold = (st_ff != CIE_ST_RUN);
  assign irq_taken = taken_ff;
  assign pc_load = pc_load_ff;
  assign pc_load_addr = pc_addr_ff;
  assign stack = stack_ff;
  assign stack_ptr = sp_ff;

  sequence s_entry_push;
    ##2 stack_ff.wr ##1 stack_ff.wr;
  endsequence

  sequence s_pop_pair;
    ##2 stack_ff.rd ##1 stack_ff.rd;
  endsequence

  property p_accept_needs_enables;
    @(posedge sys_clk) disable iff (rst)
    accept |-> (gie_ff && (|(hw_clr & src_enable & (irq_flags | src_level))));
  endproperty
  a_accept_needs_enables: assert property (p_accept_needs_enables) else $error("interrupt taken while disabled");

  property p_gie_cleared;
    @(posedge sys_clk) disable iff (rst)
    accept |=> !gie_ff;
  endproperty
  a_gie_cleared: assert property (p_gie_cleared) else $error("global enable not cleared on entry");

  property p_cli_blocks;
    @(posedge sys_clk) disable iff (rst)
    instr.cli |=> (!taken_ff && !gie_ff);
  endproperty
  a_cli_blocks: assert property (p_cli_blocks) else $error("interrupt taken with cli");

  property p_entry_len;
    @(posedge sys_clk) disable iff (rst)
    (accept && !cpu_sleeping) |-> s_entry_push ##2 (pc_load_ff && pc_addr_ff == vec_ff);
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry sequence wrong");

  property p_wake_len;
    @(posedge sys_clk) disable iff (rst)
    (accept && cpu_sleeping) |=> !pc_load_ff [*8] ##1 pc_load_ff;
  endproperty
  a_wake_len: assert property (p_wake_len) else $error("wake entry not lengthened by four");

  property p_sp_push;
    @(posedge sys_clk) disable iff (rst || sp_wr)
    (accept && !cpu_sleeping) |-> ##3 (sp_ff == $past(sp_ff, 3) - 16'h0002);
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("stack pointer not lowered by two");

  property p_ret_seq;
    @(posedge sys_clk) disable iff (rst || sp_wr)
    ret_start |-> s_pop_pair ##2 (pc_load_ff && gie_ff && sp_ff == $past(sp_ff, 5) + 16'h0002);
  endproperty
  a_ret_seq: assert property (p_ret_seq) else $error("return sequence wrong");

  property p_ret_sets_gie;
    @(posedge sys_clk) disable iff (rst || core_status_register_wr.wr || instr.cli)
    ret_start |-> ##5 gie_ff;
  endproperty
  a_ret_sets_gie: assert property (p_ret_sets_gie) else $error("return did not set global enable");

  property p_lock;
    @(posedge sys_clk) disable iff (rst)
    ((app_lock_irq_bit && !pc_in_boot) || (boot_lock_irq_bit && pc_in_boot)) |=> !taken_ff;
  endproperty
  a_lock: assert property (p_lock) else $error("interrupt taken in locked region");

endmodule

//--- inc/cie_pkg.sv
// Shared constants and types for the interrupt entry and return unit.
// Assumes one core clock and a synchronous active-high reset.
package cie_pkg;

  localparam int CIE_NSRC = 8;
  localparam int CIE_IDX_W = 3;
  localparam int CIE_PC_W = 15;
  localparam int CIE_SP_W = 16;
  localparam int CIE_GIE_BIT = 7;

  // Table bases in program words; boot start is a plain default
  localparam logic [14:0] CIE_APP_START = 15'h0000;
  localparam logic [14:0] CIE_BOOT_START = 15'h7000;
  // Each vector slot holds a two-word jump
  localparam logic [14:0] CIE_VEC_STRIDE = 15'h0002;

  // Sources that request only while their condition stands
  localparam logic [7:0] CIE_LEVEL_MASK = 8'hC0;

  // Cycle counts of the sequences
  localparam logic [2:0] CIE_ENTRY_CYC = 3'h4;
  localparam logic [2:0] CIE_WAKE_CYC = 3'h4;
  localparam logic [2:0] CIE_RET_CYC = 3'h4;

  // Values after reset
  localparam logic [15:0] CIE_SP_RST = 16'h0000;
  localparam logic CIE_GIE_RST = 1'b0;

  typedef enum {
    CIE_ST_BOOT,
    CIE_ST_RUN,
    CIE_ST_WAKE,
    CIE_ST_ENTRY,
    CIE_ST_RETURN
  } cie_state_t;

  // Instruction events from the sequencer, all in the cycle the instruction ends
  typedef struct packed {
    logic boundary;
    logic sei;
    logic cli;
    logic return_from_irq_instr;
  } cie_instr_t;

  // Software write of the status register byte
  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } cie_core_status_register_wr_t;

  // Byte-wide stack memory request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cie_stack_t;

endpackage

//--- rtl/cie_flag_bank.sv
// Interrupt flags of the peripheral sources, edge-flagged and level type.
// Assumes events and levels come from logic on the same clock.
`timescale 1ns/10ps
module cie_flag_bank
  import cie_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [CIE_NSRC-1:0] src_event,
  input wire logic [CIE_NSRC-1:0] src_level,
  input wire logic [CIE_NSRC-1:0] src_enable,
  input wire logic sw_clr_wr,
  input wire logic [CIE_NSRC-1:0] sw_clr_data,
  input wire logic [CIE_NSRC-1:0] hw_clr,
  output logic [CIE_NSRC-1:0] flags,
  output logic [CIE_NSRC-1:0] pending
);

  logic [CIE_NSRC-1:0] flag_ff;
  logic [CIE_NSRC-1:0] nxt_flag;

  genvar gi;
  generate
    for (gi = 0; gi < CIE_NSRC; gi++)
    begin : g_src
      if (CIE_LEVEL_MASK[gi])
      begin : g_level
        // No memory: a condition that goes away is simply not taken
        assign nxt_flag[gi] = 1'b0;
        assign pending[gi] = src_level[gi] & src_enable[gi];
      end
      else
      begin : g_edge
        // Set wins over both clears so a coincident event is kept
        assign nxt_flag[gi] = src_event[gi] |
          (flag_ff[gi] & ~hw_clr[gi] & ~(sw_clr_wr & sw_clr_data[gi]));
        assign pending[gi] = flag_ff[gi] & src_enable[gi];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      flag_ff <= '0;
    else
      flag_ff <= nxt_flag;
  end

  assign flags = flag_ff;

endmodule

//--- rtl/cie_vec_sel.sv
// Fixed-priority pick among pending sources and its vector address.
// Assumes pending already carries the individual enables.
`timescale 1ns/10ps
module cie_vec_sel
  import cie_pkg::*;
(
  input wire logic [CIE_NSRC-1:0] pending,
  input wire logic tbl_sel,
  output logic valid,
  output logic [CIE_NSRC-1:0] onehot,
  output logic [CIE_PC_W-1:0] vec_addr
);

  function automatic logic [CIE_IDX_W-1:0] lowest_idx(input logic [CIE_NSRC-1:0] v);
    logic [CIE_IDX_W-1:0] r;
    r = '0;
    for (int i = CIE_NSRC - 1; i >= 0; i--)
      if (v[i])
        r = CIE_IDX_W'(i);
    return r;
  endfunction

  logic [CIE_IDX_W-1:0] idx;
  logic [CIE_PC_W-1:0] tbl_base;
  logic [CIE_PC_W-1:0] slot;

  assign valid = |pending;
  assign idx = lowest_idx(pending);
  assign onehot = valid ? (CIE_NSRC'(1) << idx) : '0;
  assign tbl_base = tbl_sel ? CIE_BOOT_START : CIE_APP_START;
  // Slot zero is the reset vector, so sources start one slot up
  assign slot = CIE_PC_W'(idx) + 15'h0001;
  assign vec_addr = CIE_PC_W'(tbl_base + CIE_PC_W'(slot * CIE_VEC_STRIDE));

endmodule

//--- sim/cie_stack_mem.sv
// Byte stack memory standing where the core data memory would be.
// Assumes one request a cycle from the unit on the same clock.
`timescale 1ns/10ps
module cie_stack_mem
  import cie_pkg::*;
(
  input wire logic sys_clk,
  input wire cie_stack_t stack,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem_ff [0:4095];
  logic [7:0] rdata_ff = 8'hA5;

  always @(posedge sys_clk)
  begin
    if (stack.wr)
      mem_ff[stack.addr[11:0]] <= stack.wdata;
    // Data toggles outside a read answer so a stale byte never passes for a good one
    if (stack.rd)
      rdata_ff <= mem_ff[stack.addr[11:0]];
    else
      rdata_ff <= ~rdata_ff;
  end

  assign stack_rdata = rdata_ff;
endmodule

//--- sim/test_cie_irq_core.sv
// Self-checking bench of the interrupt entry and return unit.
// Assumes the bench plays the sequencer and sources; the stack model answers reads.
`timescale 1ns/10ps
module test_cie_irq_core;
  import cie_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] src_event = 8'h00, src_level = 8'h00, src_enable = 8'h00, flag_clr_data = 8'h00;
  logic flag_clr_wr = 1'b0, vector_table_select = 1'b0, boot_reset_fuse = 1'b0;
  logic app_lock_irq_bit = 1'b0, boot_lock_irq_bit = 1'b0, pc_in_boot = 1'b0, cpu_sleeping = 1'b0;
  cie_instr_t instr = 4'h0;
  cie_core_status_register_wr_t core_status_register_wr = 9'h000;
  logic sp_wr = 1'b0;
  logic [15:0] sp_wdata = 16'h0000;
  logic [14:0] pc_cur = 15'h0000;
  logic [7:0] stack_rdata, irq_flags;
  logic global_irq_enable, seq_hold, irq_taken, pc_load;
  logic [14:0] pc_load_addr;
  cie_stack_t stack;
  logic [15:0] stack_ptr;
  int n_mismatch = 0;
  int comparisons = 0;

  cie_irq_core dut (.sys_clk(sys_clk), .rst(rst), .src_event(src_event), .src_level(src_level),
    .src_enable(src_enable), .flag_clr_wr(flag_clr_wr), .flag_clr_data(flag_clr_data),
    .vector_table_select(vector_table_select), .boot_reset_fuse(boot_reset_fuse),
    .app_lock_irq_bit(app_lock_irq_bit), .boot_lock_irq_bit(boot_lock_irq_bit), .pc_in_boot(pc_in_boot),
    .cpu_sleeping(cpu_sleeping), .instr(instr), .core_status_register_wr(core_status_register_wr), .sp_wr(sp_wr), .sp_wdata(sp_wdata),
    .pc_cur(pc_cur), .stack_rdata(stack_rdata), .irq_flags(irq_flags),
    .global_irq_enable(global_irq_enable), .seq_hold(seq_hold), .irq_taken(irq_taken), .pc_load(pc_load),
    .pc_load_addr(pc_load_addr), .stack(stack), .stack_ptr(stack_ptr));

  cie_stack_mem partner (.sys_clk(sys_clk), .stack(stack), .stack_rdata(stack_rdata));

  initial
  begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Bounded wait for the program counter load, counting cycles in n
  task automatic wait_load(inout int n);
    while (pc_load !== 1'b1)
    begin
      if (n > 14)
      begin
        n_mismatch++;
        finish_test();
      end
      else
      begin
        step();
        n++;
      end
    end
  endtask

  task automatic pulse(input cie_instr_t ev);
    instr = ev;
    step();
    instr = 4'h0;
  endtask

  task automatic core_status_register_write(input logic [7:0] val);
    core_status_register_wr = {1'b1, val};
    step();
    core_status_register_wr = 9'h000;
  endtask

  // Accept at this boundary (or wake if sleeping), then walk the entry
  task automatic take(input logic [14:0] pc, input int idx, input int lat);
    logic [15:0] sp0;
    logic [14:0] vec;
    int n;
    sp0 = stack_ptr;
    vec = (vector_table_select ? CIE_BOOT_START : CIE_APP_START) + CIE_VEC_STRIDE * 15'(idx + 1);
    pc_cur = pc;
    pulse(lat == 5 ? 4'h8 : 4'h0);
    cpu_sleeping = 1'b0;
    chk("irq_taken", 1, 32'(irq_taken));
    chk("hold in entry", 1, 32'(seq_hold));
    chk("gie after accept", 0, 32'(global_irq_enable));
    chk("flag after accept", 0, 32'(irq_flags[idx]));
    repeat (lat - 4) step();
    chk("push low", {7'h0, 1'b1, sp0, pc[7:0]}, {7'h0, stack.wr, stack.addr, stack.wdata});
    step();
    chk("push high", {7'h0, 1'b1, sp0 - 16'h1, 1'b0, pc[14:8]}, {7'h0, stack.wr, stack.addr, stack.wdata});
    n = lat - 2;
    wait_load(n);
    chk("entry cycles", lat, n);
    chk("hold released", 0, 32'(seq_hold));
    chk("vector", 32'(vec), 32'(pc_load_addr));
    chk("sp after push", 32'(sp0 - 16'h2), 32'(stack_ptr));
    step();
  endtask

  task automatic ret(input logic [14:0] pc);
    logic [15:0] sp0;
    int n;
    sp0 = stack_ptr;
    pulse(4'h9);
    n = 1;
    wait_load(n);
    chk("return cycles", 5, n);
    chk("return address", 32'(pc), 32'(pc_load_addr));
    chk("gie after return", 1, 32'(global_irq_enable));
    chk("sp after pop", 32'(sp0 + 16'h2), 32'(stack_ptr));
    step();
  endtask

  task automatic s_reset(input logic fuse);
    int n;
    rst = 1'b1;
    boot_reset_fuse = fuse;
    repeat (8) step();
    chk("reset state", 32'h02000000, {6'h0, seq_hold, global_irq_enable, irq_flags, stack_ptr});
    rst = 1'b0;
    n = 0;
    wait_load(n);
    chk("reset vector", 32'(fuse ? CIE_BOOT_START : CIE_APP_START), 32'(pc_load_addr));
    step();
    sp_wr = 1'b1;
    sp_wdata = 16'h10FF;
    step();
    sp_wr = 1'b0;
  endtask

  task automatic s_priority();
    src_enable = 8'h24;
    src_event = 8'h27;
    step();
    src_event = 8'h00;
    chk("flags while disabled", 32'h27, 32'(irq_flags));
    pulse(4'hC);
    chk("no take at sei", 0, 32'(irq_taken));
    repeat (2) step();
    chk("no take without boundary", 0, 32'(irq_taken));
    take(15'h1234, 2, 5);
    ret(15'h1234);
    step();
    chk("no take after return", 0, 32'(irq_taken));
    take(15'h0456, 5, 5);
    ret(15'h0456);
    chk("disabled flags kept", 32'h03, 32'(irq_flags));
    flag_clr_wr = 1'b1;
    flag_clr_data = 8'h01;
    step();
    flag_clr_wr = 1'b0;
    step();
    chk("write one clears", 32'h02, 32'(irq_flags));
  endtask

  task automatic s_cli_nest();
    src_enable = 8'h0A;
    src_event = 8'h08;
    step();
    src_event = 8'h00;
    pulse(4'hA);
    chk("no take at cli", 0, {irq_taken, global_irq_enable});
    core_status_register_write(8'h7F);
    chk("other status bits", 0, 32'(global_irq_enable));
    step();
    core_status_register_write(8'h80);
    chk("status bit 7", 1, 32'(global_irq_enable));
    vector_table_select = 1'b1;
    take(15'h2345, 1, 5);
    src_event = 8'h08;
    step();
    src_event = 8'h00;
    core_status_register_write(8'h80);
    take(15'h7010, 3, 5);
    ret(15'h7010);
    ret(15'h2345);
    vector_table_select = 1'b0;
  endtask

  task automatic s_level_lock();
    src_enable = 8'h00;
    src_level = 8'h40;
    step();
    src_level = 8'h00;
    src_enable = 8'h40;
    pulse(4'h8);
    chk("vanished level", 0, 32'(irq_taken));
    src_level = 8'h40;
    app_lock_irq_bit = 1'b1;
    step();
    pulse(4'h8);
    chk("app lock", 0, 32'(irq_taken));
    app_lock_irq_bit = 1'b0;
    boot_lock_irq_bit = 1'b1;
    pc_in_boot = 1'b1;
    step();
    pulse(4'h8);
    chk("boot lock", 0, 32'(irq_taken));
    boot_lock_irq_bit = 1'b0;
    step();
    cpu_sleeping = 1'b1;
    take(15'h0100, 6, 9);
    src_level = 8'h00;
    ret(15'h0100);
  endtask

  initial
  begin
    s_reset(1'b1);
    s_reset(1'b0);
    s_priority();
    s_cli_nest();
    s_level_lock();
    finish_test();
  end
endmodule
